// ===== design/keypad_display_entry_status.sv
`timescale 1ns/100ps

// ****************************************
// Character FIFO
// ****************************************
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  wire do_push = in_valid & in_ready;
  wire do_pop  = out_valid & out_ready;
  wire [AW-1:0] wnext = (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
  wire [AW-1:0] rnext = (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rptr];

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wptr] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
        wptr <= wnext;
      if (do_pop)
        rptr <= rnext;
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule : char_fifo

// ****************************************
// Entry, display and status logic
// ****************************************
module keypad_display_entry_status #(
  // Clocks per internal tick; a bench may shorten it to reach scan-rate behaviour
  parameter int PRESCALE_COUNT = keypad_pkg::PRESCALE
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire keypad_pkg::pins_s        pins,
  input  wire keypad_pkg::input_mode_e  mode,
  input  wire logic                     special_error_mode,
  input  wire logic                     auto_increment_flag,
  input  wire logic                     right_entry,
  input  wire logic                     display_16,
  input  wire logic                     read_display,
  input  wire logic                     disp_addr_load,
  input  wire logic [3:0]               disp_addr_value,
  input  wire logic                     sensor_addr_load,
  input  wire logic [2:0]               sensor_addr_value,
  input  wire logic                     end_interrupt,
  input  wire logic                     clear_fifo_bit,
  input  wire logic                     clear_display,
  input  wire logic                     key_event,
  input  wire keypad_pkg::key_s         key,
  input  wire logic                     multi_key,
  output logic                          irq,
  output logic [7:0]                    data_out,
  output logic                          data_oe,
  output logic [3:0]                    scan_outputs,
  output logic [7:0]                    display_data
);
  import keypad_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pins_s s1, s2, p;
  logic [11:0] div;
  logic [6:0]  dig_cnt;
  logic [3:0]  scan;
  logic [7:0]  disp_ram [DISP_DEPTH];
  logic [7:0]  sens_ram [SENS_ROWS];
  logic [3:0]  disp_addr;
  logic [3:0]  offset;
  logic [3:0]  clr_idx;
  logic [2:0]  sens_ptr;
  logic        sens_wr_en;
  logic        changed;
  logic        sens_irq;
  logic        err_flag;
  logic        ovr;
  logic        und;
  disp_state_e disp_state;
  status_s     st;
  logic [7:0]  fifo_data;
  logic [3:0]  fifo_count;
  logic        fifo_valid;
  logic        fifo_ready;

  // Pins pass two flops; p, taken from s2, is the edge reference and also supplies the cs_n and register_select seen at a strobe end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= PINS_IDLE;
      s2 <= PINS_IDLE;
      p  <= PINS_IDLE;
    end
    else
    begin
      s1 <= pins;
      s2 <= s1;
      p  <= s2;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  wire sens_mode   = (mode == MODE_SENSOR);
  wire kb_mode     = (mode == MODE_KEYBOARD);
  wire rd_end      = ~p.cs_n & ~p.rd_n & s2.rd_n & ~p.register_select;
  wire wr_end      = ~p.cs_n & ~p.wr_n & s2.wr_n & ~p.register_select;
  wire stb_rise    = ~p.strobe_or_control_input & s2.strobe_or_control_input;
  wire rd_disp     = rd_end & read_display;
  wire rd_sens     = rd_end & ~read_display & sens_mode;
  wire rd_fifo     = rd_end & ~read_display & ~sens_mode;
  wire tick        = (div == 12'(PRESCALE_COUNT - 1));
  wire digit_end   = tick & (dig_cnt == 7'(DIGIT_TICKS - 1));
  wire [3:0] mask  = display_16 ? 4'hf : 4'h7;
  wire [2:0] row   = scan[2:0];
  wire row_diff    = (sens_ram[row] != s2.return_inputs);
  wire sens_cap    = sens_mode & digit_end & sens_wr_en;
  wire sens_change_end = sens_cap & (row == 3'h7) & (changed | row_diff);
  wire disp_wr_ok  = wr_end & (disp_state == DISP_RUN);
  wire [3:0] addr_next = (disp_addr + 4'h1) & mask;
  wire [3:0] show_idx  = right_entry ? ((scan + offset) & mask) : scan;
  wire kb_push     = kb_mode & key_event & ~err_flag;
  wire st_push     = (mode == MODE_STROBED) & stb_rise;
  wire push_req    = kb_push | st_push;
  wire [7:0] push_data = kb_push ? {s2.strobe_or_control_input, s2.shift_input, key}
                                 : s2.return_inputs;
  wire overrun_ev  = push_req & ~fifo_ready;
  wire underrun_ev = rd_fifo & ~fifo_valid;
  wire irq_clr_rd  = rd_sens & ~auto_increment_flag;
  wire [7:0] rd_src = read_display ? disp_ram[disp_addr]
                    : sens_mode ? sens_ram[sens_ptr] : fifo_data;

  wire [SENS_ROWS-1:0] row_closed;
  genvar gi;
  generate
    for (gi = 0; gi < SENS_ROWS; gi++)
    begin : g_closed
      // Returns idle high; a closed contact reads as zero
      assign row_closed[gi] = ~&sens_ram[gi];
    end
  endgenerate

  assign st.unavailable  = (disp_state == DISP_CLEAR);
  assign st.sensor_error = sens_mode ? |row_closed : (special_error_mode & err_flag);
  assign st.overrun      = ovr;
  assign st.underrun     = und;
  assign st.full         = (fifo_count == 4'(FIFO_DEPTH));
  assign st.count        = fifo_count[2:0];

  char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (clear_fifo_bit),
    .in_valid  (push_req),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (rd_fifo),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  // ****************************************
  // Timing chain and scan
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div          <= '0;
      dig_cnt      <= '0;
      scan         <= '0;
      scan_outputs <= '0;
      display_data <= BLANK_CODE;
    end
    else
    begin
      div <= tick ? '0 : div + 12'h001;
      if (tick)
        dig_cnt <= digit_end ? '0 : dig_cnt + 7'h01;
      if (digit_end)
        scan <= (scan == mask) ? 4'h0 : scan + 4'h1;
      scan_outputs <= scan;
      display_data <= disp_ram[show_idx];
    end
  end

  // ****************************************
  // Display RAM, clear and entry
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (disp_state == DISP_CLEAR && tick)
      disp_ram[clr_idx] <= BLANK_CODE;
    else if (disp_wr_ok)
      disp_ram[disp_addr] <= s2.data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      disp_state <= DISP_CLEAR;
      clr_idx    <= '0;
      disp_addr  <= '0;
      offset     <= '0;
    end
    else
    begin
      case (disp_state)
        DISP_RUN:
          if (clear_display)
          begin
            disp_state <= DISP_CLEAR;
            clr_idx    <= '0;
          end
        DISP_CLEAR:
          if (tick)
          begin
            clr_idx <= clr_idx + 4'h1;
            if (clr_idx == 4'(CLEAR_TICKS - 1))
              disp_state <= DISP_RUN;
          end
        default:
          disp_state <= DISP_RUN;
      endcase
      if (disp_addr_load)
        disp_addr <= disp_addr_value & mask;
      else if ((disp_wr_ok || rd_disp) && auto_increment_flag)
        disp_addr <= addr_next;
      // Window origin follows the last written cell so it shows rightmost
      if (disp_wr_ok && right_entry)
        offset <= addr_next;
    end
  end

  // ****************************************
  // Sensor RAM
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < SENS_ROWS; i++)
        sens_ram[i] <= SENS_RESET;
    end
    else if (sens_cap)
      sens_ram[row] <= s2.return_inputs;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sens_ptr   <= '0;
      sens_wr_en <= 1'b1;
      changed    <= 1'b0;
    end
    else
    begin
      if (clear_fifo_bit)
        sens_ptr <= '0;
      else if (sensor_addr_load)
        sens_ptr <= sensor_addr_value;
      else if (rd_sens && auto_increment_flag)
        sens_ptr <= sens_ptr + 3'h1;
      if (sens_cap)
        changed <= (row != 3'h7) & (changed | row_diff);
      if (sens_change_end)
        sens_wr_en <= 1'b0;
      else if (end_interrupt)
        sens_wr_en <= 1'b1;
    end
  end

  // ****************************************
  // Flags, interrupt and host read port
  // ****************************************
  // Every flag lets a same-cycle set win over its clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sens_irq <= 1'b0;
      err_flag <= 1'b0;
      ovr      <= 1'b0;
      und      <= 1'b0;
      irq      <= 1'b0;
      data_out <= '0;
      data_oe  <= 1'b0;
    end
    else
    begin
      sens_irq <= sens_change_end
                | (sens_irq & ~(end_interrupt | clear_fifo_bit | irq_clr_rd));
      err_flag <= (special_error_mode & multi_key) | (err_flag & ~clear_fifo_bit);
      ovr      <= overrun_ev | (ovr & ~clear_fifo_bit);
      und      <= underrun_ev | (und & ~clear_fifo_bit);
      irq      <= sens_irq | err_flag | (fifo_valid & ~sens_mode);
      data_oe  <= ~s2.cs_n & ~s2.rd_n;
      data_out <= s2.register_select ? st : rd_src;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_SENS_COPY: assert property (sens_cap |=> sens_ram[$past(row)] == $past(s2.return_inputs))
    else $error("sensor row not copied");
  AST_SENS_IRQ: assert property (sens_change_end |=> sens_irq ##1 irq)
    else $error("sensor change did not raise irq");
  AST_IRQ_READ_CLR: assert property (irq_clr_rd && !sens_change_end |=> !sens_irq)
    else $error("first read did not clear sensor irq");
  AST_KB_FORMAT: assert property (kb_push && !fifo_valid && !clear_fifo_bit |=>
    fifo_data == {$past(s2.strobe_or_control_input), $past(s2.shift_input), $past(key)})
    else $error("keyboard character layout wrong");
  AST_STROBE: assert property (st_push && !fifo_valid && !clear_fifo_bit |=>
    fifo_data == $past(s2.return_inputs))
    else $error("strobed byte not stored");
  AST_OVERRUN: assert property (push_req && !fifo_ready && !rd_fifo && !clear_fifo_bit |=>
    ovr && fifo_count == 4'h8)
    else $error("overrun not flagged");
  AST_UNDERRUN: assert property (rd_fifo && !fifo_valid |=> und)
    else $error("underrun not flagged");
  AST_CLEAR_BUSY: assert property (clear_display && disp_state == DISP_RUN |=>
    st.unavailable [*8])
    else $error("display unavailable dropped early");
  AST_ADDR_INC: assert property (disp_wr_ok && auto_increment_flag && !disp_addr_load |=>
    disp_addr == (($past(disp_addr) + 4'h1) & $past(mask)))
    else $error("display address did not advance");
  AST_FIFO_POP: assert property (rd_fifo && fifo_valid && !push_req && !clear_fifo_bit |=>
    fifo_count == $past(fifo_count) - 4'h1)
    else $error("fifo read did not advance");

  COV_SENS_IRQ: cover property (sens_change_end ##[1:8] irq);
  COV_FULL: cover property (overrun_ev);
  COV_RIGHT_WRAP: cover property (disp_wr_ok && right_entry && disp_addr == mask);
endmodule : keypad_display_entry_status

// ===== design/keypad_pkg.sv
package keypad_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_KHZ   = 250000;
  localparam int INT_CLK_KHZ   = 100;
  localparam int PRESCALE      = SYS_CLK_KHZ / INT_CLK_KHZ;
  // Digit-on 480 us plus 160 us blanking per digit
  localparam int DIGIT_TIME_US = 640;
  localparam int DIGIT_TICKS   = (DIGIT_TIME_US * INT_CLK_KHZ) / 1000;
  localparam int CLEAR_TIME_US = 160;
  localparam int CLEAR_TICKS   = (CLEAR_TIME_US * INT_CLK_KHZ) / 1000;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int FIFO_DEPTH = 8;
  localparam int DISP_DEPTH = 16;
  localparam int SENS_ROWS  = 8;
  localparam logic [7:0] BLANK_CODE = 8'h00;
  localparam logic [7:0] SENS_RESET = 8'hff;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_KEYBOARD = 3'b001,
    MODE_STROBED  = 3'b010,
    MODE_SENSOR   = 3'b100
  } input_mode_e;

  typedef enum logic [1:0] {
    DISP_RUN   = 2'b01,
    DISP_CLEAR = 2'b10
  } disp_state_e;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       register_select;
    logic [7:0] data;
    logic [7:0] return_inputs;
    logic       strobe_or_control_input;
    logic       shift_input;
  } pins_s;

  localparam pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'hff, 1'b0, 1'b0};

  typedef struct packed {
    logic [2:0] row;
    logic [2:0] col;
  } key_s;

  typedef struct packed {
    logic       unavailable;
    logic       sensor_error;
    logic       overrun;
    logic       underrun;
    logic       full;
    logic [2:0] count;
  } status_s;

endpackage : keypad_pkg

// ===== tb/host_model.sv
`timescale 1ns/100ps

// ****************************************
// Host processor on the parallel bus
// ****************************************
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            register_select,
  output logic [7:0]      data
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    register_select = 1'b0;
    data = 8'h00;
  end

  // Strobes held six cycles, three times the pin synchroniser depth, so no edge is lost
  task automatic access(input logic is_read, input logic rs, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    @(negedge clk);
    cs_n            = 1'b0;
    register_select = rs;
    data            = wdata;
    rd_n            = ~is_read;
    wr_n            = is_read;
    repeat (6) @(negedge clk);
    rdata = data_out;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    // Released bus shows the inverse, so stale data never passes for held data
    data = ~wdata;
    repeat (3) @(negedge clk);
  endtask : access
endmodule : host_model

// ===== tb/keypad_display_entry_status_tb_top.sv
`timescale 1ns/100ps

`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("BAD at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module keypad_display_entry_status_tb_top;
  import keypad_pkg::*;

  logic        clk, rst, stb, shift, special_error_mode, auto_increment_flag, right_entry;
  logic        display_16, read_display, disp_addr_load, end_interrupt, clear_fifo_bit;
  logic        clear_display, key_event, multi_key, sensor_addr_load;
  logic [3:0]  disp_addr_value;
  logic [2:0]  sensor_addr_value;
  logic [7:0]  ret;
  key_s        key;
  input_mode_e mode;
  pins_s       pins;
  wire         cs_n, rd_n, wr_n, rs, irq, data_oe;
  wire  [7:0]  hdata, data_out, display_data;
  wire  [3:0]  scan_outputs;
  int          cycles, fails, compares, i, j, n;

  // Short prescale so scan, sensor and clear timing fit the run
  localparam int TB_PRESCALE = 4;

  assign pins = '{cs_n, rd_n, wr_n, rs, hdata, ret, stb, shift};

  host_model host (.clk(clk), .data_out(data_out), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
                   .register_select(rs), .data(hdata));

  keypad_display_entry_status #(.PRESCALE_COUNT(TB_PRESCALE)) uut (
    .clk(clk), .rst(rst), .pins(pins), .mode(mode), .special_error_mode(special_error_mode),
    .auto_increment_flag(auto_increment_flag), .right_entry(right_entry),
    .display_16(display_16), .read_display(read_display), .disp_addr_load(disp_addr_load),
    .disp_addr_value(disp_addr_value), .sensor_addr_load(sensor_addr_load),
    .sensor_addr_value(sensor_addr_value), .end_interrupt(end_interrupt),
    .clear_fifo_bit(clear_fifo_bit), .clear_display(clear_display), .key_event(key_event),
    .key(key), .multi_key(multi_key), .irq(irq), .data_out(data_out), .data_oe(data_oe),
    .scan_outputs(scan_outputs), .display_data(display_data));

  // ****************************************
  // Clock, timeout and closing report
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fails++;
      $display("BAD at %0t: run did not complete", $time);
      finish_test();
    end
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic rd(input logic rs_sel, input logic [7:0] exp);
    logic [7:0] got;
    fork
      host.access(1'b1, rs_sel, 8'h00, got);
      begin
        repeat (5) @(negedge clk);
        `CHK(data_oe, 1'b1)
      end
    join
    `CHK(got, exp)
    `CHK(data_oe, 1'b0)
  endtask : rd

  task automatic wr(input logic [7:0] v);
    logic [7:0] junk;
    host.access(1'b0, 1'b0, v, junk);
  endtask : wr

  task automatic push(input logic [7:0] v);
    ret = v;
    stb = 1'b1;
    repeat (4) @(negedge clk);
    stb = 1'b0;
    repeat (4) @(negedge clk);
  endtask : push

  task automatic key_push(input logic ctl, input logic sh, input logic [2:0] r,
                          input logic [2:0] c);
    stb   = ctl;
    shift = sh;
    repeat (4) @(negedge clk);
    key       = '{r, c};
    key_event = 1'b1;
    @(negedge clk);
    key_event = 1'b0;
    repeat (2) @(negedge clk);
  endtask : key_push

  task automatic clr_fifo();
    clear_fifo_bit = 1'b1;
    @(negedge clk);
    clear_fifo_bit = 1'b0;
  endtask : clr_fifo

  task automatic load(input logic [3:0] a);
    disp_addr_value = a;
    disp_addr_load  = 1'b1;
    @(negedge clk);
    disp_addr_load = 1'b0;
  endtask : load

  // Bounded so a stuck scan counter cannot hang the run
  task automatic wait_scan(input logic [3:0] v, output int k);
    for (k = 0; k < 5000 && scan_outputs !== v; k++)
      @(negedge clk);
  endtask : wait_scan

  // Waits for digit 0, where display_data is the leftmost byte
  task automatic show(input logic [7:0] exp);
    int k;
    repeat (3) @(negedge clk);
    wait_scan(4'h0, k);
    `CHK(scan_outputs, 4'h0)
    `CHK(display_data, exp)
  endtask : show

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    {rst, stb, shift, special_error_mode, auto_increment_flag, right_entry} = 6'h20;
    {display_16, read_display, disp_addr_load, end_interrupt, clear_fifo_bit} = 5'h10;
    {clear_display, key_event, multi_key, sensor_addr_load} = 4'h0;
    {disp_addr_value, sensor_addr_value, ret, key, mode} = {7'h00, 8'hff, 6'h00, MODE_KEYBOARD};
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    rd(1'b1, 8'h80);
    repeat (80) @(negedge clk);
    rd(1'b1, 8'h00);
    mode = MODE_STROBED;
    for (i = 0; i < 9; i++)
    begin
      push(8'h10 + 8'(i));
      if (i == 0)
        rd(1'b1, 8'h01);
    end
    rd(1'b1, 8'h28);
    for (i = 0; i < 8; i++)
      rd(1'b0, 8'h10 + 8'(i));
    rd(1'b1, 8'h20);
    wr(8'h00);
    host.access(1'b1, 1'b0, 8'h00, ret);
    ret = 8'hff;
    rd(1'b1, 8'h30);
    clr_fifo();
    rd(1'b1, 8'h00);
    mode = MODE_KEYBOARD;
    key_push(1'b1, 1'b0, 3'd5, 3'd3);
    key_push(1'b0, 1'b1, 3'd2, 3'd6);
    stb = 1'b0;
    rd(1'b1, 8'h02);
    rd(1'b0, 8'hab);
    rd(1'b0, 8'h56);
    special_error_mode = 1'b1;
    multi_key = 1'b1;
    @(negedge clk);
    multi_key = 1'b0;
    key_push(1'b0, 1'b0, 3'd1, 3'd1);
    rd(1'b1, 8'h40);
    `CHK(irq, 1'b1)
    clr_fifo();
    special_error_mode = 1'b0;
    rd(1'b1, 8'h00);
    read_display = 1'b1;
    auto_increment_flag = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      display_16 = (i == 0);
      n = (i == 0) ? 16 : 8;
      load(4'h0);
      for (j = 0; j <= n; j++)
        wr(8'(n * 8 + j));
      show(8'(n * 9));
    end
    load(4'h1);
    rd(1'b0, 8'h41);
    auto_increment_flag = 1'b0;
    load(4'h3);
    wr(8'h33);
    wr(8'h44);
    rd(1'b0, 8'h44);
    rd(1'b0, 8'h44);
    display_16 = 1'b1;
    right_entry = 1'b1;
    auto_increment_flag = 1'b1;
    load(4'h0);
    for (j = 0; j < 16; j++)
      wr(8'hc0 + 8'(j));
    show(8'hc0);
    wr(8'hd0);
    show(8'hc1);
    load(4'h5);
    wr(8'he5);
    show(8'hc6);
    clear_display = 1'b1;
    @(negedge clk);
    clear_display = 1'b0;
    rd(1'b1, 8'h80);
    repeat (80) @(negedge clk);
    show(8'h00);
    auto_increment_flag = 1'b0;
    read_display = 1'b0;
    display_16 = 1'b0;
    wait_scan(4'h0, n);
    wait_scan(4'h1, n);
    wait_scan(4'h0, n);
    `CHK(n, 7 * DIGIT_TICKS * TB_PRESCALE)
    mode = MODE_SENSOR;
    ret  = 8'hfe;
    repeat (5000) @(negedge clk);
    `CHK(irq, 1'b1)
    rd(1'b1, 8'h40);
    sensor_addr_value = 3'h7;
    sensor_addr_load  = 1'b1;
    @(negedge clk);
    sensor_addr_load = 1'b0;
    ret = 8'h7f;
    rd(1'b0, 8'hfe);
    `CHK(irq, 1'b0)
    repeat (5000) @(negedge clk);
    rd(1'b0, 8'hfe);
    end_interrupt = 1'b1;
    @(negedge clk);
    end_interrupt = 1'b0;
    repeat (5000) @(negedge clk);
    `CHK(irq, 1'b1)
    rd(1'b0, 8'h7f);
    finish_test();
  end
endmodule : keypad_display_entry_status_tb_top
